// [include/err_class_pkg.sv]
// Package: error codes, limits and input kinds of the fault classifier
package err_class_pkg;

	// Error codes shown in place of the reading
	localparam logic [3:0] code_none        = 4'h0;
	localparam logic [3:0] code_input_over  = 4'h1;
	localparam logic [3:0] code_input_under = 4'h2;
	localparam logic [3:0] code_disp_over   = 4'h3;
	localparam logic [3:0] code_disp_under  = 4'h4;
	localparam logic [3:0] code_sys_fault   = 4'h7;
	localparam logic [3:0] code_sens_fault  = 4'h9;
	localparam logic [3:0] code_calc_fault  = 4'hb;

	// Display limits in digits
	localparam logic signed [23:0] disp_max = 24'sd9999;
	localparam logic signed [23:0] disp_min = -24'sd1999;

	// Loop current floor in microamperes
	localparam int unsigned loop_min_ua = 4000;
	localparam logic [15:0] loop_min    = 16'(loop_min_ua);

	// Input kinds
	localparam logic [2:0] kind_voltage = 3'h0;
	localparam logic [2:0] kind_live0   = 3'h1;
	localparam logic [2:0] kind_cur0    = 3'h2;
	localparam logic [2:0] kind_rtd     = 3'h3;
	localparam logic [2:0] kind_tc      = 3'h4;
	localparam logic [2:0] kind_pulse   = 3'h5;

	// Synchroniser depth for outside levels
	localparam int unsigned sync_depth = 2;
	localparam int unsigned n_flags    = 9;

	// Index of each synchronised flag
	localparam int unsigned f_adc_hi   = 0;
	localparam int unsigned f_adc_lo   = 1;
	localparam int unsigned f_open     = 2;
	localparam int unsigned f_short    = 3;
	localparam int unsigned f_cnt_ovf  = 4;
	localparam int unsigned f_cnt_unf  = 5;
	localparam int unsigned f_self     = 6;
	localparam int unsigned f_temp     = 7;
	localparam int unsigned f_calc     = 8;

endpackage

// [rtl/flag_sync.sv]
// Two-stage synchroniser for a group of level flags
`timescale 1ns/1ps
module flag_sync #(
	parameter int unsigned width = 9
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic [width-1:0] async_in,
	output logic      [width-1:0] sync_out
);

	typedef struct packed {
		logic [width-1:0] meta;
		logic [width-1:0] sync;
	} state_s;

	state_s state_r;
	state_s state_nxt;

	assign sync_out = state_r.sync;

	always_comb begin
		state_nxt      = state_r;
		state_nxt.meta = async_in;
		// First stage feeds only the second stage
		state_nxt.sync = state_r.meta;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

endmodule // flag_sync

// [rtl/measurement_error_classifier.sv]
// Fault classifier choosing the error code that replaces the reading
//
// Operation
// - Over-range code when the input is above range or, for pulse input, the counter overflows.
// - Under-range code when input is below range, live-zero loop under 4 mA or pulse counter underflows.
// - Input range codes clear by themselves once the input is back in limits.
// - Live-zero short gives over-range and loop break under-range; RTD open or short shows the sensor-fault code.
// - Display-over code above 9999, cleared once the value is below 9999.
// - Display-under code below -1999, cleared once the value is above -1999.
// - Self-check or temperature failure shows the system-fault code.
// - Open or shorted RTD, or open thermocouple, shows the sensor-fault code.
// - A faulty value feeding the display computation shows the calc-fault code.
// - While any fault holds, the code replaces the numeric reading.
`timescale 1ns/1ps
module measurement_error_classifier (
	input  wire logic               clock,
	input  wire logic               rst_b,
	input  wire logic [2:0]         input_kind,
	input  wire logic               adc_above,
	input  wire logic               adc_below,
	input  wire logic [15:0]        loop_ua,
	input  wire logic               loop_valid,
	input  wire logic               sensor_open,
	input  wire logic               sensor_short,
	input  wire logic               cnt_overflow,
	input  wire logic               cnt_underflow,
	input  wire logic               self_check_fail,
	input  wire logic               temp_out_of_range,
	input  wire logic               calc_input_bad,
	input  wire logic signed [23:0] disp_value,
	input  wire logic               disp_valid,
	output logic                    fault_active,
	output logic [3:0]              err_code,
	output logic signed [23:0]      shown_value,
	output logic                    show_code
);

	////////////////////////////////////////////////////////////////////////
	// Synchronise front-end flags; value words are same-domain

	logic [err_class_pkg::n_flags-1:0] raw_flags;
	logic [err_class_pkg::n_flags-1:0] flags;

	assign raw_flags = {calc_input_bad, temp_out_of_range, self_check_fail,
		cnt_underflow, cnt_overflow, sensor_short, sensor_open,
		adc_below, adc_above};

	flag_sync #(
		.width(err_class_pkg::n_flags)
	) u_sync (
		.clock   (clock),
		.rst_b   (rst_b),
		.async_in(raw_flags),
		.sync_out(flags)
	);

	////////////////////////////////////////////////////////////////////////
	// State

	typedef enum logic [1:0] {
		st_ok    = 2'b01,
		st_fault = 2'b10
	} mode_e;

	typedef struct packed {
		mode_e              mode;
		logic               disp_over;
		logic               disp_under;
		logic               fault;
		logic [3:0]         code;
		logic signed [23:0] shown;
		logic               show;
	} state_s;

	state_s state_r;
	state_s state_nxt;

	logic is_rtd;
	logic is_tc;
	logic is_live0;
	logic is_pulse;
	logic in_over;
	logic in_under;
	logic sens_bad;
	logic sys_bad;
	logic calc_bad;
	logic [3:0] pick;

	////////////////////////////////////////////////////////////////////////
	// Classification

	always_comb begin
		is_rtd   = (input_kind == err_class_pkg::kind_rtd);
		is_tc    = (input_kind == err_class_pkg::kind_tc);
		is_live0 = (input_kind == err_class_pkg::kind_live0);
		is_pulse = (input_kind == err_class_pkg::kind_pulse);

		// Pure levels, so both range codes drop as soon as the cause goes
		in_over = flags[err_class_pkg::f_adc_hi]
			| (is_pulse & flags[err_class_pkg::f_cnt_ovf])
			| (is_rtd & flags[err_class_pkg::f_open])
			| (is_live0 & flags[err_class_pkg::f_short]);
		in_under = flags[err_class_pkg::f_adc_lo]
			| (is_pulse & flags[err_class_pkg::f_cnt_unf])
			| (is_live0 & loop_valid
				& (loop_ua < err_class_pkg::loop_min))
			| (is_rtd & flags[err_class_pkg::f_short])
			| (is_live0 & flags[err_class_pkg::f_open]);

		sens_bad = (is_rtd & (flags[err_class_pkg::f_open]
				| flags[err_class_pkg::f_short]))
			| (is_tc & flags[err_class_pkg::f_open]);
		sys_bad = flags[err_class_pkg::f_self]
			| flags[err_class_pkg::f_temp];
		calc_bad = flags[err_class_pkg::f_calc];

		state_nxt = state_r;

		// Display range flags: set beyond the limit, clear only once
		// strictly inside it, so exactly 9999 or -1999 holds the code
		if (disp_valid) begin
			if (disp_value > err_class_pkg::disp_max) begin
				state_nxt.disp_over = 1'b1;
			end else if (disp_value < err_class_pkg::disp_max) begin
				state_nxt.disp_over = 1'b0;
			end
			if (disp_value < err_class_pkg::disp_min) begin
				state_nxt.disp_under = 1'b1;
			end else if (disp_value > err_class_pkg::disp_min) begin
				state_nxt.disp_under = 1'b0;
			end
		end
		// Counter result overruns the display as well
		if (is_pulse & flags[err_class_pkg::f_cnt_ovf]) begin
			state_nxt.disp_over = 1'b1;
		end
		if (is_pulse & flags[err_class_pkg::f_cnt_unf]) begin
			state_nxt.disp_under = 1'b1;
		end

		// Fixed priority picks one code
		if (sys_bad) begin
			pick = err_class_pkg::code_sys_fault;
		end else if (sens_bad) begin
			pick = err_class_pkg::code_sens_fault;
		end else if (in_over) begin
			pick = err_class_pkg::code_input_over;
		end else if (in_under) begin
			pick = err_class_pkg::code_input_under;
		end else if (state_r.disp_over) begin
			pick = err_class_pkg::code_disp_over;
		end else if (state_r.disp_under) begin
			pick = err_class_pkg::code_disp_under;
		end else if (calc_bad) begin
			pick = err_class_pkg::code_calc_fault;
		end else begin
			pick = err_class_pkg::code_none;
		end

		state_nxt.code = pick;
		unique case (state_r.mode)
			st_ok: begin
				if (pick != err_class_pkg::code_none) begin
					state_nxt.mode = st_fault;
				end
			end
			st_fault: begin
				if (pick == err_class_pkg::code_none) begin
					state_nxt.mode = st_ok;
				end
			end
		endcase

		// Reading is blanked in favour of the code while a fault holds
		state_nxt.fault = (state_nxt.mode == st_fault);
		state_nxt.show  = (pick != err_class_pkg::code_none);
		if (pick == err_class_pkg::code_none) begin
			state_nxt.shown = disp_value;
		end else begin
			state_nxt.shown = '0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_r      <= '0;
			state_r.mode <= st_ok;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign fault_active = state_r.fault;
	assign err_code     = state_r.code;
	assign shown_value  = state_r.shown;
	assign show_code    = state_r.show;

endmodule // measurement_error_classifier

// [testbench/display_model.sv]
// Display side model showing the reading or the error code
`timescale 1ns/1ps
module display_model (
	input  wire logic               clock,
	input  wire logic               show_code,
	input  wire logic [3:0]         err_code,
	input  wire logic signed [23:0] shown_value,
	output logic      [23:0]        face
);
	// A code is drawn as E digits plus the code nibble
	always_ff @(posedge clock) begin
		face <= show_code ? {20'hee000, err_code} : shown_value;
	end
endmodule // display_model

// [testbench/measurement_error_classifier_asserts.sv]
// Port assertions for the fault classifier
`timescale 1ns/1ps
module classifier_checker (
	input wire logic clock, rst_b, adc_above, adc_below, loop_valid,
	input wire logic sensor_open, sensor_short, cnt_overflow, cnt_underflow,
	input wire logic self_check_fail, temp_out_of_range, calc_input_bad,
	input wire logic disp_valid, fault_active, show_code,
	input wire logic [2:0] input_kind,
	input wire logic [3:0] err_code,
	input wire logic [15:0] loop_ua,
	input wire logic signed [23:0] disp_value, shown_value
);
	logic hot, q8, volt, inr;
	assign hot = self_check_fail | temp_out_of_range;
	assign q8 = !(hot | adc_above | adc_below | sensor_open | sensor_short
		| cnt_overflow | cnt_underflow);
	assign volt = input_kind == err_class_pkg::kind_voltage;
	assign inr = disp_valid && disp_value < err_class_pkg::disp_max
		&& disp_value > err_class_pkg::disp_min;
	// Three samples cover the flag synchroniser latency
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////
	a_sys_code: assert property (
		hot[*3] |=> err_code == err_class_pkg::code_sys_fault)
		else $error("system code missing");
	a_sensor_code: assert property (
		(!hot && (sensor_open | sensor_short)
		&& input_kind == err_class_pkg::kind_rtd)[*3]
		|=> err_code == err_class_pkg::code_sens_fault)
		else $error("sensor code missing");
	a_input_over: assert property (
		(adc_above && !adc_below && !hot && !sensor_open && !sensor_short
		&& volt)[*3] |=> err_code == err_class_pkg::code_input_over)
		else $error("input over code missing");
	a_disp_over: assert property (
		(q8 && volt && disp_valid && disp_value > err_class_pkg::disp_max)[*3]
		|=> err_code == err_class_pkg::code_disp_over)
		else $error("display over code missing");
	a_over_hold: assert property (
		(q8 && volt)[*3] ##0 (disp_valid && disp_value == 24'sd9999)[*2]
		##0 (err_code == err_class_pkg::code_disp_over)
		|=> err_code == err_class_pkg::code_disp_over)
		else $error("display over dropped at limit");
	a_back_clear: assert property (
		(q8 && !calc_input_bad && volt && inr)[*3]
		|=> !fault_active && shown_value == $past(disp_value))
		else $error("code not cleared");
	a_calc_code: assert property (
		(q8 && calc_input_bad && volt && inr)[*3]
		|=> err_code == err_class_pkg::code_calc_fault)
		else $error("calc code missing");
	a_code_tie: assert property (
		show_code == fault_active && fault_active == (err_code != 4'h0)
		&& (!fault_active || shown_value == 24'sd0))
		else $error("code and reading disagree");
	c_sys: cover property (err_code == err_class_pkg::code_sys_fault);
	c_under: cover property (err_code == err_class_pkg::code_disp_under);
	c_calc: cover property (err_code == err_class_pkg::code_calc_fault);
endmodule // classifier_checker

// [testbench/measurement_error_classifier_bench.sv]
// Self-checking bench for the fault classifier
`timescale 1ns/1ps
module measurement_error_classifier_bench;
	localparam logic [3:0] io = err_class_pkg::code_input_over;
	localparam logic [3:0] iu = err_class_pkg::code_input_under;
	localparam logic [3:0] sf = err_class_pkg::code_sens_fault;
	localparam logic [3:0] dv = err_class_pkg::code_disp_over;
	localparam logic [3:0] du = err_class_pkg::code_disp_under;
	localparam logic [2:0] kv = err_class_pkg::kind_voltage;
	localparam logic [2:0] kl = err_class_pkg::kind_live0;
	localparam logic [2:0] kr = err_class_pkg::kind_rtd;
	logic               clock, rst_b, fa, sc, lv, vv;
	logic [8:0]         fl;
	logic [2:0]         kind;
	logic [15:0]        loop;
	logic [3:0]         code;
	logic [23:0]        face;
	logic signed [23:0] val, shown;
	int                 mismatches, checked, cyc;
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	measurement_error_classifier dut (
		.clock(clock), .rst_b(rst_b), .input_kind(kind),
		.adc_above(fl[0]), .adc_below(fl[1]), .loop_ua(loop),
		.loop_valid(lv), .sensor_open(fl[2]), .sensor_short(fl[3]),
		.cnt_overflow(fl[4]), .cnt_underflow(fl[5]),
		.self_check_fail(fl[6]), .temp_out_of_range(fl[7]),
		.calc_input_bad(fl[8]), .disp_value(val), .disp_valid(vv),
		.fault_active(fa), .err_code(code), .shown_value(shown),
		.show_code(sc));
	display_model screen (.clock(clock), .show_code(sc), .err_code(code),
		.shown_value(shown), .face(face));
	////////////////////////////////////////////////////////////////////////
	task automatic go(input logic [8:0] f, input logic [2:0] k,
		input logic signed [23:0] v, input logic [3:0] e);
		logic [23:0] x;
		@(posedge clock);
		fl <= f;
		kind <= k;
		val <= v;
		// Flags need two sync stages, output and display edges
		repeat (5) @(posedge clock);
		#1;
		x = (e == 4'h0) ? v : {20'hee000, e};
		checked++;
		if (code !== e || face !== x || fa !== (e != 4'h0) || sc !== fa) begin
			mismatches++;
			$display("Error err_code exp %h got %h face exp %h got %h",
				e, code, x, face);
		end
	endtask
	task automatic t_input;
		go(9'h001, kv, 24'sd100, io);
		go(9'h000, kv, 24'sd100, 4'h0);
		go(9'h002, kv, 24'sd100, iu);
		go(9'h010, err_class_pkg::kind_pulse, 24'sd100, io);
		go(9'h020, err_class_pkg::kind_pulse, 24'sd100, iu);
		@(posedge clock);
		loop <= 16'h0f9f;
		go(9'h000, kl, 24'sd100, iu);
		@(posedge clock);
		loop <= 16'h0fa0;
		go(9'h000, kl, 24'sd100, 4'h0);
	endtask
	task automatic t_sensor;
		go(9'h004, kr, 24'sd100, sf);
		go(9'h008, kr, 24'sd100, sf);
		go(9'h004, err_class_pkg::kind_tc, 24'sd100, sf);
		go(9'h008, kl, 24'sd100, io);
		go(9'h004, kl, 24'sd100, iu);
	endtask
	task automatic t_disp;
		go(9'h000, kv, 24'sd10000, dv);
		go(9'h000, kv, 24'sd9999, dv);
		go(9'h000, kv, 24'sd9998, 4'h0);
		go(9'h000, kv, -24'sd2000, du);
		go(9'h000, kv, -24'sd1999, du);
		go(9'h000, kv, -24'sd1998, 4'h0);
	endtask
	task automatic t_prio;
		go(9'h040, kv, 24'sd100, err_class_pkg::code_sys_fault);
		go(9'h080, kv, 24'sd100, err_class_pkg::code_sys_fault);
		go(9'h1ff, kr, 24'sd10000, err_class_pkg::code_sys_fault);
		go(9'h13c, kr, 24'sd10000, sf);
		go(9'h101, kv, 24'sd10000, io);
		go(9'h100, kv, 24'sd10000, dv);
		go(9'h100, kv, 24'sd100, err_class_pkg::code_calc_fault);
	endtask
	task automatic t_valid;
		go(9'h000, kv, 24'sd10000, dv);
		@(posedge clock);
		vv <= 1'b0;
		go(9'h000, kv, 24'sd100, dv);
		@(posedge clock);
		vv <= 1'b1;
		lv <= 1'b0;
		loop <= 16'h0f9f;
		go(9'h000, kl, 24'sd100, 4'h0);
		@(posedge clock);
		lv <= 1'b1;
		loop <= 16'h2710;
	endtask
	task automatic wrap_up;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		rst_b = 1'b0;
		fl = 9'h000;
		kind = kv;
		loop = 16'h2710;
		lv = 1'b1;
		vv = 1'b1;
		val = 24'sd0;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		t_input();
		t_sensor();
		t_disp();
		t_prio();
		t_valid();
		wrap_up();
	end
endmodule // measurement_error_classifier_bench
bind measurement_error_classifier classifier_checker chk (.clock(clock),
	.rst_b(rst_b), .adc_above(adc_above), .adc_below(adc_below),
	.loop_valid(loop_valid), .sensor_open(sensor_open),
	.sensor_short(sensor_short), .cnt_overflow(cnt_overflow),
	.cnt_underflow(cnt_underflow), .self_check_fail(self_check_fail),
	.temp_out_of_range(temp_out_of_range), .calc_input_bad(calc_input_bad),
	.disp_valid(disp_valid), .fault_active(fault_active),
	.show_code(show_code), .input_kind(input_kind), .err_code(err_code),
	.loop_ua(loop_ua), .disp_value(disp_value), .shown_value(shown_value));
